/* File: design/pcs_pkg.sv */
/*
 * Constants, field positions and carrier types of the configuration
 * command and status register. Assumes a clocked configuration access
 * port and bus event pulses on the same clock.
 */
// Function
// [RULE1] Bit 0 enables I/O decode; reset value taken from the I/O strap.
// [RULE2] Bit 1 enables memory decode; reset value taken from the memory strap.
// [RULE3] Bit 2 enables bus mastering, clear after reset; clear blocks initiator cycles.
// [RULE4] Bit 3 reads zero; special cycles are never answered.
// [RULE5] Bit 4 reads zero; master uses plain memory write only.
// [RULE6] Bit 5 reads zero; palette accesses are treated as ordinary.
// [RULE7] Bit 6 enables parity response; clear still records errors, without PERR#.
// [RULE8] Bit 7 reads zero; no address or data stepping.
// [RULE9] Bit 8 enables SERR#; address parity report needs bits 8 and 6.
// [RULE10] Bit 9 reads zero; master fast back-to-back only to one target.
// [RULE11] Reserved and unimplemented bits read as zero.
// [RULE12] Bit 20 reads one: capability list pointer at offset 34H.
// [RULE13] Bit 21 reads zero: 33MHz only.
// [RULE14] Bit 23 reads one; target accepts fast back-to-back from different agents.
// [RULE15] Bit 24 set on master parity error with response enabled; write one clears.
// [RULE16] Bits 26:25 read 01, medium device-select timing.
// [RULE17] Bit 27 set on signalled target abort; write one clears.
// [RULE18] Bit 28 set on received target abort as master; write one clears.
// [RULE19] Bit 29 set on master abort except special cycle; write one clears.
// [RULE20] Bit 30 set whenever SERR# is driven; software write clears; the code clears it only on a written one.
// [RULE21] Bit 31 set on any detected parity error; write one clears.
// [RULE22] Reached by configuration cycles at offset 04h with byte enables.
package pcs_pkg;

    // ************************************************************
    // Map and field positions
    // ************************************************************
    localparam logic [7:0] PCS_CMD_STAT_OFFSET = 8'h04;
    localparam int PCS_B_IO = 0;
    localparam int PCS_B_MEM = 1;
    localparam int PCS_B_BME = 2;
    localparam int PCS_B_PERR_RESP = 6;
    localparam int PCS_B_SERR_EN = 8;
    localparam int PCS_NFLAGS = 6;
    localparam logic [31:0] PCS_FIXED_READ = 32'h0290_0000;
    localparam logic [31:0] PCS_RESERVED_MASK = 32'h006f_feb8;
    localparam logic [31:0] PCS_FIXED_MASK = 32'h06f0_0000;
    localparam logic [1:0] PCS_DEVSEL_MEDIUM = 2'h1;
    localparam logic [31:0] PCS_DATA_ZERO = 32'h0000_0000;

    typedef enum {
        PCS_FLG_MDPE, PCS_FLG_STA, PCS_FLG_RTA, PCS_FLG_RMA, PCS_FLG_SSE, PCS_FLG_DPE
    } pcs_flag_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } pcs_cfg_req_t;

    typedef struct packed {
        logic master_data_perr;
        logic target_abort_sent;
        logic target_abort_rcvd;
        logic master_abort_rcvd;
        logic special_cycle;
        logic addr_parity_err;
        logic parity_err_detected;
    } pcs_bus_evt_t;

    typedef struct packed {
        logic io_space_en;
        logic mem_space_en;
        logic bus_master_en;
        logic special_cycle_monitor;
        logic mwi_allowed;
        logic palette_snoop;
        logic perr_resp_en;
        logic stepping_allowed;
        logic serr_en;
        logic fast_b2b_other_targets;
        logic accept_fast_b2b;
        logic [1:0] devsel_timing;
    } pcs_ctrl_t;

    // Status bit that each sticky flag occupies
    function automatic int pcs_flag_bit(input int idx);
        case (idx)
            PCS_FLG_MDPE: return 24;
            PCS_FLG_STA: return 27;
            PCS_FLG_RTA: return 28;
            PCS_FLG_RMA: return 29;
            PCS_FLG_SSE: return 30;
            default: return 31;
        endcase
    endfunction : pcs_flag_bit

    // Byte lane that carries a given bit
    function automatic int pcs_lane(input int b);
        return b / 8;
    endfunction : pcs_lane

endpackage : pcs_pkg

/* File: design/pcs_pin_sync.sv */
/*
 * Two-stage synchroniser for static strap pins.
 * Assumes the pins are steady while reset is held.
 */
`timescale 1ns/100ps
module pcs_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic i_core_clk,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta;

    // No reset: the straps must be sampled while reset is still held
    always_ff @(posedge i_core_clk) begin
        meta <= i_pin;
        o_q <= meta;
    end
endmodule : pcs_pin_sync

/* File: design/pcs_sticky_flag.sv */
/*
 * One hardware-set, write-one-to-clear status flag.
 * Assumes set and clear are single-clock pulses on the core clock.
 */
`timescale 1ns/100ps
module pcs_sticky_flag (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_set,
    input wire logic i_clear,
    output logic o_flag
);
    // Set wins over a simultaneous clear so no event is lost
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end
endmodule : pcs_sticky_flag

/* File: design/pcs_command_status.sv */
/*
 * Configuration command and status register with its control outputs,
 * event flags and SERR# driver.
 * Assumes bus interface logic on the same clock supplies one-cycle
 * event pulses and the configuration access port; straps are pins.
 */
`timescale 1ns/100ps
module pcs_command_status
    import pcs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_io_enable_default_strap,
    input wire logic i_memory_enable_default_strap,
    input wire pcs_cfg_req_t i_cfg,
    input wire pcs_bus_evt_t i_evt,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    output pcs_ctrl_t o_ctrl,
    output logic o_serr_n_out,
    output logic o_serr_n_oe
);

    // ************************************************************
    // Access decode
    // ************************************************************
    function automatic logic hits_reg(input pcs_cfg_req_t r);
        return r.valid && (r.addr[7:2] == PCS_CMD_STAT_OFFSET[7:2]);
    endfunction : hits_reg

    logic cfg_wr;
    logic cfg_rd;
    logic [1:0] strap_q;
    pcs_ctrl_t ctrl;
    logic [PCS_NFLAGS-1:0] flag;
    logic [PCS_NFLAGS-1:0] flag_set;
    logic [PCS_NFLAGS-1:0] flag_clr;
    logic serr_drive;
    logic [31:0] next_image;

    assign cfg_wr = hits_reg(i_cfg) && i_cfg.write; // RULE22
    assign cfg_rd = hits_reg(i_cfg) && !i_cfg.write; // RULE22

    pcs_pin_sync #(
        .WIDTH(2)
    ) u_strap_sync (
        .i_core_clk(i_core_clk),
        .i_pin({i_memory_enable_default_strap, i_io_enable_default_strap}),
        .o_q(strap_q)
    );

    // ************************************************************
    // Command half
    // ************************************************************
    // Straps are static; reset must be held for at least three edges
    // Hard-wired fields here too, so the struct has a single driver
    always_ff @(posedge i_core_clk) begin
        ctrl.special_cycle_monitor <= 1'b0; // RULE4
        ctrl.mwi_allowed <= 1'b0; // RULE5
        ctrl.palette_snoop <= 1'b0; // RULE6
        ctrl.stepping_allowed <= 1'b0; // RULE8
        ctrl.fast_b2b_other_targets <= 1'b0; // RULE10
        ctrl.accept_fast_b2b <= 1'b1; // RULE14
        ctrl.devsel_timing <= PCS_DEVSEL_MEDIUM; // RULE16
        if (!i_reset_n) begin
            ctrl.io_space_en <= strap_q[0]; // RULE1
            ctrl.mem_space_en <= strap_q[1]; // RULE2
            ctrl.bus_master_en <= 1'b0; // RULE3
            ctrl.perr_resp_en <= 1'b0; // RULE7
            ctrl.serr_en <= 1'b0; // RULE9
        end else if (cfg_wr) begin
            if (i_cfg.byte_en[pcs_lane(PCS_B_IO)]) begin
                ctrl.io_space_en <= i_cfg.wdata[PCS_B_IO]; // RULE1
                ctrl.mem_space_en <= i_cfg.wdata[PCS_B_MEM]; // RULE2
                ctrl.bus_master_en <= i_cfg.wdata[PCS_B_BME]; // RULE3
                ctrl.perr_resp_en <= i_cfg.wdata[PCS_B_PERR_RESP]; // RULE7
            end
            if (i_cfg.byte_en[pcs_lane(PCS_B_SERR_EN)]) begin
                ctrl.serr_en <= i_cfg.wdata[PCS_B_SERR_EN]; // RULE9
            end
        end
    end

    assign o_ctrl = ctrl;

    // ************************************************************
    // SERR# driver
    // ************************************************************
    // Open drain: only ever pulls low, for one clock per report
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            serr_drive <= 1'b0;
        end else begin
            serr_drive <= i_evt.addr_parity_err && ctrl.serr_en && ctrl.perr_resp_en; // RULE9
        end
    end

    always_ff @(posedge i_core_clk) begin
        o_serr_n_out <= 1'b0;
    end

    assign o_serr_n_oe = serr_drive;

    // ************************************************************
    // Status flags
    // ************************************************************
    always_comb begin
        flag_set = '0;
        flag_set[PCS_FLG_MDPE] = i_evt.master_data_perr && ctrl.perr_resp_en; // RULE15
        flag_set[PCS_FLG_STA] = i_evt.target_abort_sent; // RULE17
        flag_set[PCS_FLG_RTA] = i_evt.target_abort_rcvd; // RULE18
        flag_set[PCS_FLG_RMA] = i_evt.master_abort_rcvd && !i_evt.special_cycle; // RULE19
        flag_set[PCS_FLG_SSE] = serr_drive; // RULE20
        flag_set[PCS_FLG_DPE] = i_evt.parity_err_detected; // RULE21
    end

    generate
        for (genvar g = 0; g < PCS_NFLAGS; g++) begin : g_flag
            assign flag_clr[g] = cfg_wr && i_cfg.byte_en[pcs_lane(pcs_flag_bit(g))]
                && i_cfg.wdata[pcs_flag_bit(g)];
            pcs_sticky_flag u_flag (
                .i_core_clk(i_core_clk),
                .i_reset_n(i_reset_n),
                .i_set(flag_set[g]),
                .i_clear(flag_clr[g]),
                .o_flag(flag[g])
            );
        end
    endgenerate

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        next_image = PCS_FIXED_READ; // RULE11 RULE12 RULE13 RULE16
        next_image[PCS_B_IO] = ctrl.io_space_en;
        next_image[PCS_B_MEM] = ctrl.mem_space_en;
        next_image[PCS_B_BME] = ctrl.bus_master_en;
        next_image[PCS_B_PERR_RESP] = ctrl.perr_resp_en;
        next_image[PCS_B_SERR_EN] = ctrl.serr_en;
        for (int k = 0; k < PCS_NFLAGS; k++) begin
            next_image[pcs_flag_bit(k)] = flag[k];
        end
    end

    // Every request is answered next clock; unmapped reads return zero
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_cfg_ack <= 1'b0;
            o_cfg_rdata <= PCS_DATA_ZERO;
        end else begin
            o_cfg_ack <= i_cfg.valid; // RULE22
            o_cfg_rdata <= cfg_rd ? next_image : PCS_DATA_ZERO; // RULE22
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_byte0_write;
        cfg_wr && i_cfg.byte_en[0];
    endsequence

    sequence s_serr_cause;
        i_evt.addr_parity_err && ctrl.serr_en && ctrl.perr_resp_en;
    endsequence

    sequence s_byte1_write;
        cfg_wr && i_cfg.byte_en[pcs_lane(PCS_B_SERR_EN)];
    endsequence

    property p_io_strap;
        @(posedge i_core_clk) $rose(i_reset_n) |-> o_ctrl.io_space_en == $past(strap_q[0]);
    endproperty
    a_io_strap: assert property (p_io_strap) else $error("io enable missed strap"); // RULE1

    property p_mem_strap;
        @(posedge i_core_clk) $rose(i_reset_n) |-> o_ctrl.mem_space_en == $past(strap_q[1]);
    endproperty
    a_mem_strap: assert property (p_mem_strap) else $error("memory enable missed strap"); // RULE2

    property p_bme_write;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            s_byte0_write |=> o_ctrl.bus_master_en == $past(i_cfg.wdata[PCS_B_BME]);
    endproperty
    a_bme_write: assert property (p_bme_write) else $error("bus master enable not written"); // RULE3

    property p_hard_off;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            !o_ctrl.special_cycle_monitor && !o_ctrl.mwi_allowed && !o_ctrl.palette_snoop
            && !o_ctrl.stepping_allowed && !o_ctrl.fast_b2b_other_targets;
    endproperty
    a_hard_off: assert property (p_hard_off) else $error("hard-wired feature enabled"); // RULE4

    property p_reserved_zero;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            o_cfg_ack |-> (o_cfg_rdata & PCS_RESERVED_MASK) == PCS_DATA_ZERO;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one"); // RULE11

    property p_fixed_ones;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            cfg_rd |=> (o_cfg_rdata & PCS_FIXED_MASK) == PCS_FIXED_READ;
    endproperty
    a_fixed_ones: assert property (p_fixed_ones) else $error("fixed capability bits wrong"); // RULE12

    property p_serr_report;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            s_serr_cause |=> o_serr_n_oe && !o_serr_n_out ##1 flag[PCS_FLG_SSE];
    endproperty
    a_serr_report: assert property (p_serr_report) else $error("SERR# report missing"); // RULE9

    property p_serr_gated;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            !(ctrl.serr_en && ctrl.perr_resp_en) |=> !o_serr_n_oe;
    endproperty
    a_serr_gated: assert property (p_serr_gated) else $error("SERR# driven while disabled"); // RULE20

    property p_mdpe_gated;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            !flag[PCS_FLG_MDPE] && !ctrl.perr_resp_en |=> !flag[PCS_FLG_MDPE];
    endproperty
    a_mdpe_gated: assert property (p_mdpe_gated) else $error("master parity flag set while off"); // RULE15

    property p_sta_set_wins;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            i_evt.target_abort_sent |=> flag[PCS_FLG_STA];
    endproperty
    a_sta_set_wins: assert property (p_sta_set_wins) else $error("target abort flag lost"); // RULE17

    property p_rma_special;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            !flag[PCS_FLG_RMA] && i_evt.special_cycle |=> !flag[PCS_FLG_RMA];
    endproperty
    a_rma_special: assert property (p_rma_special) else $error("master abort flagged on special cycle"); // RULE19

    property p_dpe_always;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            i_evt.parity_err_detected |=> flag[PCS_FLG_DPE];
    endproperty
    a_dpe_always: assert property (p_dpe_always) else $error("detected parity flag not set"); // RULE21

    property p_w1c;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            flag[PCS_FLG_RTA] && flag_clr[PCS_FLG_RTA] && !flag_set[PCS_FLG_RTA] |=> !flag[PCS_FLG_RTA];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear"); // RULE18

    property p_ack;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            i_cfg.valid |=> o_cfg_ack ##1 ($past(i_cfg.valid) || !o_cfg_ack);
    endproperty
    a_ack: assert property (p_ack) else $error("configuration access not answered"); // RULE22

    property p_io_write;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            s_byte0_write |=> o_ctrl.io_space_en == $past(i_cfg.wdata[PCS_B_IO]);
    endproperty
    a_io_write: assert property (p_io_write) else $error("io enable not written"); // RULE1

    property p_mem_write;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            s_byte0_write |=> o_ctrl.mem_space_en == $past(i_cfg.wdata[PCS_B_MEM]);
    endproperty
    a_mem_write: assert property (p_mem_write) else $error("memory enable not written"); // RULE2

    property p_bme_reset;
        @(posedge i_core_clk) $rose(i_reset_n) |-> !o_ctrl.bus_master_en;
    endproperty
    a_bme_reset: assert property (p_bme_reset) else $error("bus master on after reset"); // RULE3

    property p_perr_write;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            s_byte0_write |=> o_ctrl.perr_resp_en == $past(i_cfg.wdata[PCS_B_PERR_RESP]);
    endproperty
    a_perr_write: assert property (p_perr_write) else $error("parity response not written"); // RULE7

    property p_serr_en_write;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            s_byte1_write |=> o_ctrl.serr_en == $past(i_cfg.wdata[PCS_B_SERR_EN]);
    endproperty
    a_serr_en_write: assert property (p_serr_en_write) else $error("SERR# enable not written"); // RULE9

    property p_b2b_devsel;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            o_ctrl.accept_fast_b2b && o_ctrl.devsel_timing == PCS_DEVSEL_MEDIUM;
    endproperty
    a_b2b_devsel: assert property (p_b2b_devsel) else $error("target capability wrong"); // RULE14

    property p_write_reads_zero;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            cfg_wr |=> o_cfg_rdata == PCS_DATA_ZERO;
    endproperty
    a_write_reads_zero: assert property (p_write_reads_zero) else $error("write returned data"); // RULE22

    property p_unmapped_zero;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            i_cfg.valid && !hits_reg(i_cfg) |=> o_cfg_rdata == PCS_DATA_ZERO;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // RULE11

    property p_read_live;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            cfg_rd |=> o_cfg_rdata[PCS_B_MEM] == o_ctrl.mem_space_en;
    endproperty
    a_read_live: assert property (p_read_live) else $error("read image stale"); // RULE22

    property p_flag_read;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            cfg_rd |=> o_cfg_rdata[pcs_flag_bit(PCS_FLG_DPE)] == $past(flag[PCS_FLG_DPE]);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("parity flag misread"); // RULE21

    property p_sta_keep;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            flag[PCS_FLG_STA] && !flag_clr[PCS_FLG_STA] |=> flag[PCS_FLG_STA];
    endproperty
    a_sta_keep: assert property (p_sta_keep) else $error("target abort flag dropped"); // RULE17

    property p_sta_clear;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            flag_clr[PCS_FLG_STA] && !flag_set[PCS_FLG_STA] |=> !flag[PCS_FLG_STA];
    endproperty
    a_sta_clear: assert property (p_sta_clear) else $error("target abort flag kept"); // RULE17

    property p_rta_set;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            i_evt.target_abort_rcvd |=> flag[PCS_FLG_RTA];
    endproperty
    a_rta_set: assert property (p_rta_set) else $error("received abort flag lost"); // RULE18

    property p_rma_set;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            i_evt.master_abort_rcvd && !i_evt.special_cycle |=> flag[PCS_FLG_RMA];
    endproperty
    a_rma_set: assert property (p_rma_set) else $error("master abort flag lost"); // RULE19

    property p_mdpe_set;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            i_evt.master_data_perr && ctrl.perr_resp_en |=> flag[PCS_FLG_MDPE];
    endproperty
    a_mdpe_set: assert property (p_mdpe_set) else $error("master parity flag lost"); // RULE15

    property p_sse_cause;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            !flag[PCS_FLG_SSE] && !o_serr_n_oe |=> !flag[PCS_FLG_SSE];
    endproperty
    a_sse_cause: assert property (p_sse_cause) else $error("system error flag without SERR#"); // RULE20

    property p_dpe_clear;
        @(posedge i_core_clk) disable iff (!i_reset_n)
            flag_clr[PCS_FLG_DPE] && !flag_set[PCS_FLG_DPE] |=> !flag[PCS_FLG_DPE];
    endproperty
    a_dpe_clear: assert property (p_dpe_clear) else $error("parity flag kept"); // RULE21

endmodule : pcs_command_status

/* File: dv/pcs_host_model.sv */
/*
 * Host bridge model issuing configuration cycles to the command and
 * status register. Assumes the one-request, one-ack access port on the
 * core clock; requests are launched on the falling edge.
 */
`timescale 1ns/100ps
module pcs_host_model
    import pcs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_cfg_ack,
    input wire logic [31:0] i_cfg_rdata,
    output pcs_cfg_req_t o_cfg
);
    // ************************************************************
    // Configuration cycle
    // ************************************************************
    initial begin
        o_cfg = '0;
    end
    task automatic cfg_access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                              input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        int n;
        @(negedge i_core_clk);
        o_cfg.valid = 1'b1;
        o_cfg.write = wr;
        o_cfg.addr = addr;
        o_cfg.byte_en = be;
        o_cfg.wdata = wd;
        @(negedge i_core_clk);
        // Valid is a pulse; holding it would issue a second request
        o_cfg.valid = 1'b0;
        n = 0;
        while (i_cfg_ack !== 1'b1 && n < 4) begin
            @(negedge i_core_clk);
            n++;
        end
        ok = (i_cfg_ack === 1'b1);
        rd = i_cfg_rdata;
        // Released qualifiers must not keep the last value
        o_cfg.write = ~wr;
        o_cfg.addr = ~addr;
        o_cfg.byte_en = ~be;
        o_cfg.wdata = ~wd;
    endtask : cfg_access
endmodule : pcs_host_model

/* File: dv/test_pcs_command_status.sv */
/*
 * Self-checking bench for the command and status register.
 * Assumes the host model for configuration cycles and drives bus
 * events and straps directly on the falling clock edge.
 */
`timescale 1ns/100ps
module test_pcs_command_status
    import pcs_pkg::*;
;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic i_core_clk = 1'b0;
    logic i_reset_n;
    logic io_strap;
    logic mem_strap;
    pcs_cfg_req_t cfg;
    pcs_bus_evt_t evt;
    logic ack;
    logic [31:0] rdata;
    pcs_ctrl_t ctrl;
    logic serr_out;
    logic serr_oe;
    int errors = 0;
    int checks = 0;
    logic [6:0] ev_tab [6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h02, 7'h01};
    int bit_tab [6] = '{24, 27, 28, 29, 30, 31};
    always #4 i_core_clk = ~i_core_clk;
    pcs_command_status dut_u (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_io_enable_default_strap(io_strap),
        .i_memory_enable_default_strap(mem_strap),
        .i_cfg(cfg),
        .i_evt(evt),
        .o_cfg_ack(ack),
        .o_cfg_rdata(rdata),
        .o_ctrl(ctrl),
        .o_serr_n_out(serr_out),
        .o_serr_n_oe(serr_oe)
    );
    pcs_host_model host_u (
        .i_core_clk(i_core_clk),
        .i_cfg_ack(ack),
        .i_cfg_rdata(rdata),
        .o_cfg(cfg)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task access(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                input logic [31:0] exp, input string name);
        logic [31:0] rd;
        logic ok;
        host_u.cfg_access(w, a, be, d, rd, ok);
        if (ok !== 1'b1) begin
            errors++;
            results();
        end
        check(name, rd, exp);
    endtask : access
    task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        access(1'b1, a, be, d, 32'h0000_0000, "write data");
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 4'h0, 32'h0000_0000, exp, "read image");
    endtask : rd
    // Event pulse of one cycle, then the SERR# enable window
    task pulse(input pcs_bus_evt_t e, input logic exp_oe);
        @(negedge i_core_clk);
        evt = e;
        @(negedge i_core_clk);
        evt = '0;
        check("serr oe", serr_oe, exp_oe);
        check("serr level", serr_out, 1'b0);
        @(negedge i_core_clk);
        check("serr oe end", serr_oe, 1'b0);
    endtask : pulse
    // Control outputs in struct order; hard-wired fields per the rules
    function automatic logic [31:0] cx(input logic io, mem, bme, perr, serr);
        return 32'({io, mem, bme, 3'h0, perr, 1'b0, serr, 2'h1, PCS_DEVSEL_MEDIUM});
    endfunction : cx
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        i_reset_n = 1'b0;
        io_strap = 1'b1;
        mem_strap = 1'b0;
        evt = '0;
        repeat (3) @(negedge i_core_clk);
        i_reset_n = 1'b1;
        rd(8'h04, 32'h0290_0001);
        check("ctrl", 32'(ctrl), cx(1, 0, 0, 0, 0));
        wr(8'h04, 4'hf, 32'hffff_ffff);
        rd(8'h04, 32'h0290_0147);
        check("ctrl", 32'(ctrl), cx(1, 1, 1, 1, 1));
        wr(8'h04, 4'h1, 32'h0000_0000);
        rd(8'h04, 32'h0290_0100);
        wr(8'h04, 4'h2, 32'h0000_0000);
        wr(8'h04, 4'h4, 32'hffff_ffff);
        rd(8'h04, 32'h0290_0000);
        wr(8'h08, 4'hf, 32'hffff_ffff);
        rd(8'h08, 32'h0000_0000);
        rd(8'h04, 32'h0290_0000);
        // Gates off: the first three events must leave no trace; parity detection is not gated
        pulse(7'h40, 1'b0);
        pulse(7'h0c, 1'b0);
        pulse(7'h02, 1'b0);
        rd(8'h04, 32'h0290_0000);
        pulse(7'h01, 1'b0);
        rd(8'h04, 32'h8290_0000);
        wr(8'h04, 4'h8, 32'h0000_0000);
        rd(8'h04, 32'h8290_0000);
        wr(8'h04, 4'h8, 32'h8000_0000);
        wr(8'h04, 4'h1, 32'h0000_0040);
        pulse(7'h02, 1'b0);
        rd(8'h04, 32'h0290_0040);
        wr(8'h04, 4'h3, 32'h0000_0140);
        for (int i = 0; i < 6; i++) begin
            pulse(ev_tab[i], ev_tab[i][1]);
            rd(8'h04, 32'h0290_0140 | (32'h1 << bit_tab[i]));
            wr(8'h04, 4'h8, 32'h1 << bit_tab[i]);
            rd(8'h04, 32'h0290_0140);
        end
        // Straps must settle before reset so the synchroniser sees them
        io_strap = 1'b0;
        mem_strap = 1'b1;
        @(negedge i_core_clk);
        i_reset_n = 1'b0;
        repeat (4) @(negedge i_core_clk);
        i_reset_n = 1'b1;
        rd(8'h04, 32'h0290_0002);
        check("ctrl", 32'(ctrl), cx(0, 1, 0, 0, 0));
        results();
    end
endmodule : test_pcs_command_status
